/* File: hw/compat_regs.svh */
/*
 * Constants of the compatibility and exception unit.
 * Assumes inclusion by bare name from the package and the unit.
 */
`ifndef COMPAT_REGS_SVH
`define COMPAT_REGS_SVH

// ****************************************
// Reset start point
// ****************************************
`define RESET_CS 16'hF000
`define RESET_IP 16'hFFF0
`define RESET_PHYS 20'hFFFF0

// ****************************************
// Vector numbers
// ****************************************
`define VEC_DIVIDE 8'h00
`define VEC_STEP 8'h01
`define VEC_NMI 8'h02
`define VEC_UNDEF 8'h06
`define VEC_SEG_LIMIT 8'h09
`define VEC_PROTECT 8'h0D
`define VEC_COPROC 8'h10

// ****************************************
// Opcodes and field codes
// ****************************************
`define OP_TWO_BYTE 8'h0F
`define OP_MOV_SREG 8'h8E
`define OP_POP_MEM 8'h8F
`define OP_GROUP_FF 8'hFF
`define OP_EXCHANGE_INSTRUCTION_B 8'h86
`define OP_EXCHANGE_INSTRUCTION_W 8'h87
`define OP_ESC_TOP 5'h1B
`define SREG_CODE 3'h1
`define POP_MEM_CODE 3'h0
`define PUSH_UNDEF_CODE 3'h7
`define MOD_REG 2'h3

// ****************************************
// Limits and timing
// ****************************************
`define MAX_INSN_LEN 5'h0A
`define SHIFT_CNT_BITS 5
`define SHIFT_BASE_CLKS 6'h08
`define SHIFT_MAX_CLKS 39

`endif

/* File: hw/compat_pkg.sv */
/*
 * Types shared by the compatibility and exception unit.
 * Assumes compat_regs.svh on the include path.
 */
`default_nettype none

package compat_pkg;
    `include "compat_regs.svh"

    // One decoded instruction, valid for one cycle
    typedef struct packed {
        logic valid;
        logic [15:0] first_addr;
        logic [4:0] length;
        logic [7:0] opcode;
        logic [7:0] modrm;
    } insn_t;

    typedef struct packed {
        logic active;
        logic prefetch;
        logic lock_prefix;
    } bus_cycle_t;

    typedef struct packed {
        logic valid;
        logic external;
        logic [7:0] number;
    } vec_evt_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_RUN = 2'b10
    } shift_state_t;
endpackage : compat_pkg

`default_nettype wire

/* File: hw/compat_unit.sv */
/*
 * Exception, interrupt priority and compatibility checks of the core.
 * Assumes a decoder handing one insn_t per instruction, a pulse at each
 * instruction boundary, and asynchronous interrupt pins.
 */
`default_nettype none

`include "compat_regs.svh"

module compat_unit (
    input wire logic core_clk,
    input wire logic resetn,
    input wire compat_pkg::insn_t insn,
    input wire logic insn_boundary,
    input wire logic trap_flag,
    input wire logic intr_enable,
    input wire logic interrupt_return_done,
    input wire logic seg_limit_err,
    input wire logic nmi_pin,
    input wire logic intr_pin,
    input wire logic coproc_err_pin,
    input wire compat_pkg::bus_cycle_t bus_cycle,
    input wire logic shift_start,
    input wire logic [7:0] shift_count,
    input wire logic div_req,
    input wire logic div_word,
    input wire logic [31:0] div_quot,
    output var compat_pkg::vec_evt_t vec_evt,
    output logic prot_setup,
    output logic [15:0] coproc_insn_addr,
    output logic [15:0] reset_cs,
    output logic [15:0] reset_ip,
    output logic [19:0] fetch_start,
    output logic bus_hold,
    output logic [4:0] shift_eff,
    output logic shift_busy,
    output logic shift_done,
    output logic nmi_masked
);
    import compat_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic nmi_s1_r, nmi_s2_r, nmi_old_r;
    logic intr_s1_r, intr_s2_r;
    logic cerr_s1_r, cerr_s2_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {nmi_s1_r, nmi_s2_r, nmi_old_r} <= 3'h0;
            {intr_s1_r, intr_s2_r} <= 2'h0;
            {cerr_s1_r, cerr_s2_r} <= 2'h0;
        end else begin
            nmi_s1_r <= nmi_pin;
            nmi_s2_r <= nmi_s1_r;
            nmi_old_r <= nmi_s2_r;
            intr_s1_r <= intr_pin;
            intr_s2_r <= intr_s1_r;
            cerr_s1_r <= coproc_err_pin;
            cerr_s2_r <= cerr_s1_r;
        end
    end

    wire nmi_edge = nmi_s2_r & ~nmi_old_r;

    // ****************************************
    // Reset start point
    // ****************************************
    // reset fetch address
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reset_cs <= `RESET_CS;
            reset_ip <= `RESET_IP;
            fetch_start <= `RESET_PHYS;
        end
    end

    // ****************************************
    // Decode checks
    // ****************************************
    wire [2:0] reg_field = insn.modrm[5:3];
    wire mem_operand = insn.modrm[7:6] != `MOD_REG;
    wire too_long = insn.length > `MAX_INSN_LEN;
    wire mov_to_cs = insn.opcode == `OP_MOV_SREG && reg_field == `SREG_CODE;
    wire is_setup = insn.opcode == `OP_TWO_BYTE;
    wire bad_pop = insn.opcode == `OP_POP_MEM && reg_field != `POP_MEM_CODE;
    wire bad_push = insn.opcode == `OP_GROUP_FF
        && reg_field == `PUSH_UNDEF_CODE;
    wire ud_fault = insn.valid & (too_long | mov_to_cs);
    wire gp_fault = insn.valid & ~ud_fault & (bad_pop | bad_push);
    wire is_esc = insn.opcode[7:3] == `OP_ESC_TOP;
    wire is_exchange_instruction_mem = mem_operand
        && (insn.opcode == `OP_EXCHANGE_INSTRUCTION_B || insn.opcode == `OP_EXCHANGE_INSTRUCTION_W);

    wire quot_ok = div_word ? (&div_quot[31:15] | ~|div_quot[31:15])
        : (&div_quot[31:7] | ~|div_quot[31:7]);
    wire div_fault = div_req & ~quot_ok;
    wire sync_fault = ud_fault | gp_fault | div_fault;

    logic [7:0] sync_vec;
    assign sync_vec = ud_fault ? `VEC_UNDEF
        : gp_fault ? `VEC_PROTECT : `VEC_DIVIDE;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            coproc_insn_addr <= 16'h0000;
        end else if (insn.valid && is_esc && !sync_fault) begin
            coproc_insn_addr <= insn.first_addr;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prot_setup <= 1'b0;
        end else begin
            prot_setup <= insn.valid & is_setup & ~too_long;
        end
    end

    // ****************************************
    // Bus hold
    // ****************************************
    logic exchange_instruction_mem_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            exchange_instruction_mem_r <= 1'b0;
        end else if (insn.valid) begin
            exchange_instruction_mem_r <= is_exchange_instruction_mem & ~sync_fault;
        end else if (insn_boundary) begin
            exchange_instruction_mem_r <= 1'b0;
        end
    end

    wire hold_nxt = bus_cycle.active & ~bus_cycle.prefetch
        & (bus_cycle.lock_prefix | exchange_instruction_mem_r);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_hold <= 1'b0;
        end else begin
            bus_hold <= hold_nxt;
        end
    end

    // ****************************************
    // Interrupt priority
    // ****************************************
    logic nmi_pend_r, limit_pend_r;

    wire take_step = insn_boundary & ~sync_fault & trap_flag;
    wire free_slot = insn_boundary & ~sync_fault & ~trap_flag;
    wire take_nmi = free_slot & nmi_pend_r & ~nmi_masked;
    wire take_limit = free_slot & ~take_nmi & limit_pend_r & ~nmi_masked;
    wire take_cerr = free_slot & ~take_nmi & ~take_limit & cerr_s2_r;
    wire take_intr = free_slot & ~take_nmi & ~take_limit & ~take_cerr
        & intr_s2_r & intr_enable;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nmi_pend_r <= 1'b0;
            limit_pend_r <= 1'b0;
            nmi_masked <= 1'b0;
        end else begin
            nmi_pend_r <= nmi_edge | (nmi_pend_r & ~take_nmi);
            limit_pend_r <= seg_limit_err | (limit_pend_r & ~take_limit);
            nmi_masked <= take_nmi | (nmi_masked & ~interrupt_return_done);
        end
    end

    logic [7:0] vec_nxt;
    assign vec_nxt = sync_fault ? sync_vec
        : take_step ? `VEC_STEP
        : take_nmi ? `VEC_NMI
        : take_limit ? `VEC_SEG_LIMIT
        : take_cerr ? `VEC_COPROC : 8'h00;

    wire vec_any = sync_fault | take_step | take_nmi | take_limit
        | take_cerr | take_intr;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vec_evt <= '0;
        end else begin
            vec_evt <= '{valid: vec_any, external: take_intr,
                number: vec_nxt};
        end
    end

    // ****************************************
    // Shift timing
    // ****************************************
    shift_state_t sh_state_r, sh_state_nxt;
    logic [5:0] sh_left_r;

    wire [4:0] masked_cnt = shift_count[`SHIFT_CNT_BITS-1:0];
    // base plus count, at most 39
    wire [5:0] run_clks = `SHIFT_BASE_CLKS + {1'b0, masked_cnt};
    wire last_clk = sh_state_r == SH_RUN && sh_left_r == 6'h01;

    always_comb begin
        sh_state_nxt = sh_state_r;
        unique case (sh_state_r)
            SH_IDLE: begin
                if (shift_start) begin
                    sh_state_nxt = SH_RUN;
                end
            end
            SH_RUN: begin
                if (last_clk) begin
                    sh_state_nxt = SH_IDLE;
                end
            end
            default: sh_state_nxt = SH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sh_state_r <= SH_IDLE;
            sh_left_r <= 6'h00;
            shift_eff <= 5'h00;
            shift_done <= 1'b0;
        end else begin
            sh_state_r <= sh_state_nxt;
            shift_done <= last_clk;
            if (sh_state_r == SH_IDLE && shift_start) begin
                sh_left_r <= run_clks - 6'h01;
                shift_eff <= masked_cnt;
            end else if (sh_state_r == SH_RUN) begin
                sh_left_r <= sh_left_r - 6'h01;
            end
        end
    end

    assign shift_busy = sh_state_r == SH_RUN;

    // ****************************************
    // Checks
    // ****************************************
    int unsigned sh_clks_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sh_clks_r <= 0;
        end else begin
            sh_clks_r <= shift_busy ? sh_clks_r + 1 : 0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence nmi_taken_s;
        vec_evt.valid && vec_evt.number == `VEC_NMI && !vec_evt.external;
    endsequence

    long_insn_a: assert property (
        insn.valid && insn.length > `MAX_INSN_LEN
        |=> vec_evt.valid && vec_evt.number == `VEC_UNDEF)
        else $error("long instruction not refused");
    mov_cs_a: assert property (
        insn.valid && mov_to_cs |=> vec_evt.number == `VEC_UNDEF)
        else $error("code segment load not refused");
    push_pop_a: assert property (
        insn.valid && !ud_fault && (bad_pop || bad_push)
        |=> vec_evt.valid && vec_evt.number == `VEC_PROTECT)
        else $error("bad push or pop field missed");
    reset_start_a: assert property (
        fetch_start == `RESET_PHYS && reset_cs == `RESET_CS
        && reset_ip == `RESET_IP)
        else $error("reset start point wrong");
    shift_bound_a: assert property (
        sh_clks_r < `SHIFT_MAX_CLKS)
        else $error("shift longer than limit");
    shift_mask_a: assert property (
        shift_start && !shift_busy
        |=> shift_eff == $past(shift_count[4:0]))
        else $error("shift count not masked");
    hold_prefetch_a: assert property (
        bus_cycle.active && bus_cycle.prefetch |=> !bus_hold)
        else $error("bus hold during prefetch");
    hold_exchange_instruction_a: assert property (
        insn.valid && is_exchange_instruction_mem && !sync_fault ##1
        bus_cycle.active && !bus_cycle.prefetch && !insn_boundary
        |=> bus_hold)
        else $error("exchange without bus hold");
    step_first_a: assert property (
        insn_boundary && !sync_fault && trap_flag
        |=> vec_evt.number == `VEC_STEP && !vec_evt.external)
        else $error("step not first");
    nmi_mask_a: assert property (
        nmi_taken_s ##1 (!interrupt_return_done)[*2]
        |-> !(vec_evt.valid && vec_evt.number == `VEC_NMI))
        else $error("nested NMI while masked");
    nmi_pend_a: assert property (
        nmi_pend_r && !nmi_masked && insn_boundary
        && !sync_fault && !trap_flag |=> nmi_taken_s)
        else $error("pending NMI lost");
    quot_min_a: assert property (
        div_req && div_word && div_quot == 32'hFFFF_8000
        && !insn.valid |=> !vec_evt.valid)
        else $error("most negative quotient faulted");
    cerr_vec_a: assert property (
        take_cerr |=> vec_evt.number == `VEC_COPROC)
        else $error("coprocessor error wrong vector");
    esc_addr_a: assert property (
        insn.valid && is_esc && !sync_fault
        |=> coproc_insn_addr == $past(insn.first_addr))
        else $error("coprocessor address not prefix start");
endmodule : compat_unit

`default_nettype wire

/* File: sim/far_side_model.sv */
/*
 * Far side of the unit: interrupt sources and the coprocessor error line.
 * Assumes the bench raises the request inputs on core_clk edges.
 */
`default_nettype none

module far_side_model (
    input wire logic core_clk,
    input wire logic nmi_req,
    input wire logic intr_req,
    input wire logic cerr_req,
    output logic nmi_pin,
    output logic intr_pin,
    output logic coproc_err_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        nmi_pin = 1'b0;
        intr_pin = 1'b0;
        coproc_err_pin = 1'b0;
    end

    // Falling edge, so pins stay unrelated to the sampling edge
    // error line registered on the falling edge like the others
    always @(negedge core_clk) begin
        nmi_pin <= nmi_req;
        intr_pin <= intr_req;
        coproc_err_pin <= cerr_req;
    end
endmodule : far_side_model

`default_nettype wire

/* File: sim/test_compat_unit.sv */
/*
 * Self-checking bench of the compatibility and exception unit.
 * Assumes compat_pkg, compat_unit and far_side_model compiled first.
 */
`default_nettype none

`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end

module test_compat_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import compat_pkg::*;

    logic core_clk, resetn, insn_boundary, trap_flag, intr_enable;
    logic interrupt_return_done, seg_limit_err, shift_start, div_req, div_word;
    logic nmi_req, intr_req, cerr_req, nmi_pin, intr_pin, coproc_err_pin;
    logic prot_setup, bus_hold, shift_busy, shift_done, nmi_masked;
    logic [7:0] shift_count;
    logic [31:0] div_quot, r;
    logic [15:0] coproc_insn_addr, reset_cs, reset_ip, a;
    logic [19:0] fetch_start;
    logic [4:0] shift_eff;
    logic [8:0] exp_v, got_v;
    insn_t insn;
    bus_cycle_t bus_cycle;
    vec_evt_t vec_evt;
    logic [8:0] exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0001133E;
    // Opcode, modrm, length, vector (FF: none)
    logic [31:0] dec_tab[9] = '{32'h90C00B06, 32'h90C00AFF, 32'h8EC80206,
        32'h8ED802FF, 32'h8F08020D, 32'h8F0002FF, 32'hFF38020D,
        32'hFF3002FF, 32'h8F080B06};
    logic [32:0] div_tab[6] = '{{1'b0, 32'hFFFFFF80}, {1'b0, 32'hFFFFFF7F},
        {1'b0, 32'h00000080}, {1'b1, 32'hFFFF8000}, {1'b1, 32'hFFFF7FFF},
        {1'b1, 32'h00007FFF}};

    compat_unit u_dut (.core_clk(core_clk), .resetn(resetn), .insn(insn),
        .insn_boundary(insn_boundary), .trap_flag(trap_flag),
        .intr_enable(intr_enable), .interrupt_return_done(interrupt_return_done),
        .seg_limit_err(seg_limit_err), .nmi_pin(nmi_pin),
        .intr_pin(intr_pin), .coproc_err_pin(coproc_err_pin),
        .bus_cycle(bus_cycle), .shift_start(shift_start),
        .shift_count(shift_count), .div_req(div_req), .div_word(div_word),
        .div_quot(div_quot), .vec_evt(vec_evt), .prot_setup(prot_setup),
        .coproc_insn_addr(coproc_insn_addr), .reset_cs(reset_cs),
        .reset_ip(reset_ip), .fetch_start(fetch_start), .bus_hold(bus_hold),
        .shift_eff(shift_eff), .shift_busy(shift_busy),
        .shift_done(shift_done), .nmi_masked(nmi_masked));

    far_side_model u_far (.core_clk(core_clk), .nmi_req(nmi_req),
        .intr_req(intr_req), .cerr_req(cerr_req), .nmi_pin(nmi_pin),
        .intr_pin(intr_pin), .coproc_err_pin(coproc_err_pin));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // ****************************************
    // Scoreboard: events against noted vectors
    // ****************************************
    always @(posedge core_clk) begin
        if (resetn === 1'b1 && vec_evt.valid !== 1'b0) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
            got_v = {vec_evt.external, vec_evt.number};
            `CHK(got_v, exp_v)
        end
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic send(input logic [31:0] t, input logic [15:0] fa);
        @(posedge core_clk);
        if (t[7:0] != 8'hFF) exp_q.push_back({1'b0, t[7:0]});
        insn <= '{1'b1, fa, t[12:8], t[31:24], t[23:16]};
        @(posedge core_clk);
        insn <= '0;
    endtask : send

    task automatic boundary(input logic [8:0] e);
        @(posedge core_clk);
        if (e != 9'h1FF) exp_q.push_back(e);
        insn_boundary <= 1'b1;
        @(posedge core_clk);
        insn_boundary <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : boundary

    task automatic side_pulse(input logic lim);
        @(posedge core_clk);
        interrupt_return_done <= !lim;
        seg_limit_err <= lim;
        @(posedge core_clk);
        interrupt_return_done <= 1'b0;
        seg_limit_err <= 1'b0;
    endtask : side_pulse

    task automatic nmi_pulse;
        @(posedge core_clk);
        nmi_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        nmi_req <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : nmi_pulse

    task automatic divide(input logic [32:0] d);
        logic ovf;
        ovf = d[32] ? ($signed(d[31:0]) < -32768 || $signed(d[31:0]) > 32767)
                    : ($signed(d[31:0]) < -128 || $signed(d[31:0]) > 127);
        @(posedge core_clk);
        if (ovf) exp_q.push_back(9'h000);
        div_req <= 1'b1;
        div_word <= d[32];
        div_quot <= d[31:0];
        @(posedge core_clk);
        div_req <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : divide

    task automatic shift_run(input logic [7:0] c);
        int n;
        @(posedge core_clk);
        shift_start <= 1'b1;
        shift_count <= c;
        @(posedge core_clk);
        shift_start <= 1'b0;
        #1;
        n = 0;
        `CHK(shift_eff, c[4:0])
        while (shift_busy === 1'b1 && n < 60) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        // Accept cycle is the first of the base plus count clocks
        `CHK(n + 1, 8 + c[4:0])
        `CHK(n + 1 <= 39 && shift_done === 1'b1, 1'b1)
    endtask : shift_run

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {resetn, insn_boundary, trap_flag, intr_enable, interrupt_return_done} = '0;
        {seg_limit_err, shift_start, div_req, div_word, nmi_req} = '0;
        {intr_req, cerr_req, shift_count, div_quot} = '0;
        insn = '0;
        bus_cycle = '0;
        repeat (16) @(posedge core_clk);
        `CHK({reset_cs, reset_ip, fetch_start}, 52'hF000FFF0FFFF0)
        resetn <= 1'b1;
        foreach (dec_tab[i]) send(dec_tab[i], 16'h0000);
        send(32'h0FC002FF, 16'h0000);
        #1;
        `CHK(prot_setup, 1'b1)
        for (int i = 0; i < 8; i++) begin
            r = xs();
            a = r[15:0];
            send({5'h1B, i[2:0], 24'hC003FF}, a);
            #1;
            `CHK(coproc_insn_addr, a)
        end
        // Faulting escape keeps the old address
        send(32'hD8C00B06, ~a);
        #1;
        `CHK(coproc_insn_addr, a)
        foreach (div_tab[i]) divide(div_tab[i]);
        shift_run(8'hFF);
        shift_run(8'h20);
        repeat (4) begin
            r = xs();
            shift_run(r[7:0]);
        end
        send(32'h870002FF, 16'h0000);
        bus_cycle <= 3'b100;
        @(posedge core_clk);
        bus_cycle <= 3'b110;
        #1;
        `CHK(bus_hold, 1'b1)
        @(posedge core_clk);
        bus_cycle <= 3'b000;
        #1;
        `CHK(bus_hold, 1'b0)
        @(posedge core_clk);
        trap_flag <= 1'b1;
        intr_req <= 1'b1;
        intr_enable <= 1'b1;
        send(32'h90C00B06, 16'h0000);
        boundary(9'h001);
        @(posedge core_clk);
        trap_flag <= 1'b0;
        boundary(9'h100);
        @(posedge core_clk);
        cerr_req <= 1'b1;
        repeat (5) @(posedge core_clk);
        boundary(9'h010);
        @(posedge core_clk);
        {cerr_req, intr_req} <= 2'b00;
        repeat (5) @(posedge core_clk);
        nmi_pulse();
        boundary(9'h002);
        `CHK(nmi_masked, 1'b1)
        nmi_pulse();
        side_pulse(1'b1);
        boundary(9'h1FF);
        side_pulse(1'b0);
        boundary(9'h002);
        side_pulse(1'b0);
        boundary(9'h009);
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule : test_compat_unit

`default_nettype wire
